// ==== logic/enc_out_pkg.sv ====
/*
  Shared constants and types for the encoder and commutation output block.
  Assumes a single 125 MHz clock domain and a 14-bit compensated angle.
*/
`default_nettype none

package enc_out_pkg;

  // angle and field widths
  localparam int ANGLE_W    = 14;
  localparam int READBACK_W = 12;
  localparam int POLE_SEL_W = 4;
  localparam int POLE_CNT_W = 5;
  localparam int WINDOW_W   = 6;
  localparam int IDX_SEL_W  = 2;
  localparam int QUAD_BITS  = 12;
  localparam int SLEW_W     = 16;
  localparam int PHASE_CNT  = 3;
  localparam int SECTOR_W   = 3;
  localparam int SECTORS    = 6;
  localparam int SECTOR_HI  = 3;
  localparam int PHASE_STEP = 2;
  localparam int TIMER_W    = 16;

  // timing
  localparam int CLK_MHZ        = 125;
  localparam int POWER_ON_US    = 20;
  localparam int DELAY_PHASE_US = 10;
  localparam int POWER_ON_CYC   = POWER_ON_US * CLK_MHZ;
  localparam int DELAY_CYC      = DELAY_PHASE_US * CLK_MHZ;

  // reset values
  localparam logic [ANGLE_W-1:0]   ANGLE_RST = 14'h0000;
  localparam logic [QUAD_BITS-1:0] QUAD_ZERO = 12'h000;
  localparam logic [SLEW_W-1:0]    SLEW_OFF  = 16'h0000;

  typedef enum logic [1:0] {
    ST_POWER_ON,
    ST_DELAY,
    ST_CATCH_UP,
    ST_TRACK
  } startup_t;

endpackage

`default_nettype wire

// ==== logic/hyst_if.sv ====
/*
  Carrier between the output logic and its hysteresis filter.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface hyst_if
  import enc_out_pkg::*;
;
  logic [ANGLE_W-1:0]  raw_angle;
  logic                raw_valid;
  logic [WINDOW_W-1:0] window;
  logic [ANGLE_W-1:0]  filt_angle;
  logic                filt_valid;
  logic                head_dec;

  modport filter (
    input  raw_angle,
    input  raw_valid,
    input  window,
    output filt_angle,
    output filt_valid,
    output head_dec
  );

  modport user (
    output raw_angle,
    output raw_valid,
    output window,
    input  filt_angle,
    input  filt_valid,
    input  head_dec
  );
endinterface

`default_nettype wire

// ==== logic/angle_hysteresis.sv ====
/*
  Angle hysteresis filter: holds the output on reversal inside a window.
  Assumes raw_valid is a one-cycle strobe on the same clock.
*/
`default_nettype none

module angle_hysteresis
  import enc_out_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic reset_in,
  hyst_if.filter    hif
);

  logic [ANGLE_W-1:0]        out_r;
  logic                      dec_r;
  logic                      seeded_r;
  logic                      valid_r;
  logic signed [ANGLE_W-1:0] diff;
  logic signed [ANGLE_W-1:0] win_s;

  // wrap-around distance, so the window works across zero
  assign diff  = signed'(hif.raw_angle - out_r);
  assign win_s = signed'(ANGLE_W'(hif.window));

  // first sample sits at the head: the window lags the start angle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      out_r    <= ANGLE_RST;
      dec_r    <= 1'b0;
      seeded_r <= 1'b0;
      valid_r  <= 1'b0;
    end else begin
      valid_r <= hif.raw_valid;
      if (hif.raw_valid) begin
        seeded_r <= 1'b1;
        if (!seeded_r) begin
          out_r <= hif.raw_angle;
        end else if (!dec_r) begin
          if (diff >= 0) begin
            out_r <= hif.raw_angle;
          end else if (diff < -win_s) begin
            out_r <= hif.raw_angle;
            dec_r <= 1'b1;
          end
        end else begin
          if (diff <= 0) begin
            out_r <= hif.raw_angle;
          end else if (diff > win_s) begin
            out_r <= hif.raw_angle;
            dec_r <= 1'b0;
          end
        end
        // otherwise inside the window after a reversal: hold
      end
    end
  end

  assign hif.filt_angle = out_r;
  assign hif.filt_valid = valid_r;
  assign hif.head_dec   = dec_r;

endmodule

`default_nettype wire

// ==== logic/encoder_commutation_output.sv ====
/*
  Quadrature (A, B, index) and three-phase commutation (U, V, W) outputs
  driven from a measured angle, with start-up catch-up and hysteresis.
  Assumes the angle and configuration come from logic on the same clock;
  reset_in is raised at power-up, low-power exit and after self-test.
*/
`default_nettype none

module encoder_commutation_output
  import enc_out_pkg::*;
#(
  parameter int POWER_ON_CYCLES = POWER_ON_CYC,
  parameter int DELAY_CYCLES    = DELAY_CYC,
  parameter int Q_BITS          = QUAD_BITS
) (
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  input  wire logic [ANGLE_W-1:0]    angle_in,
  input  wire logic                  angle_valid_in,
  input  wire logic [POLE_SEL_W-1:0] pole_pair_sel_in,
  input  wire logic [IDX_SEL_W-1:0]  index_width_sel_in,
  input  wire logic [SLEW_W-1:0]     quadrature_slew_interval_in,
  input  wire logic [WINDOW_W-1:0]   angle_window_width_in,
  input  wire logic                  hysteresis_route_enable_in,
  output logic                       quad_a_out,
  output logic                       quad_b_out,
  output logic                       index_out,
  output logic                       phase_u_out,
  output logic                       phase_v_out,
  output logic                       phase_w_out,
  output logic [READBACK_W-1:0]      filtered_angle_readback_out,
  output logic                       rotation_head_flag_out,
  output logic                       startup_done_out
);

  hyst_if hif ();

  startup_t                     state_r;
  startup_t                     state_nxt;
  logic [TIMER_W-1:0]           timer_r;
  logic                         timer_done;
  logic [ANGLE_W-1:0]           sample_r;
  logic                         sel_valid;
  logic [ANGLE_W-1:0]           sel_angle;
  logic [Q_BITS-1:0]            q_tgt;
  logic [Q_BITS-1:0]            q_cur_r;
  logic [Q_BITS-1:0]            q_nxt;
  logic [Q_BITS-1:0]            q_diff;
  logic                         slew_on;
  logic [SLEW_W-1:0]            slew_cnt_r;
  logic                         slew_ready;
  logic                         step_now;
  logic                         in_power_on;
  logic [POLE_CNT_W-1:0]        pole_pairs;
  logic [ANGLE_W+POLE_CNT_W-1:0] elec_full;
  logic [ANGLE_W-1:0]           elec_angle;
  logic [ANGLE_W+SECTOR_W-1:0]  sector_full;
  logic [SECTOR_W-1:0]          sector;
  logic [PHASE_CNT-1:0]         phase_nxt;
  logic [PHASE_CNT-1:0]         phase_r;
  logic                         seen_sample_r;

  // hysteresis filter, window in 360/16384 degree steps
  assign hif.raw_angle = angle_in;
  assign hif.raw_valid = angle_valid_in;
  assign hif.window    = angle_window_width_in;

  angle_hysteresis u_hyst (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .hif      (hif)
  );

  // angle source selection
  assign sel_angle = hysteresis_route_enable_in ? hif.filt_angle : angle_in;
  assign sel_valid = hysteresis_route_enable_in ? hif.filt_valid : angle_valid_in;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sample_r      <= ANGLE_RST;
      seen_sample_r <= 1'b0;
    end else if (sel_valid) begin
      sample_r      <= sel_angle;
      seen_sample_r <= 1'b1;
    end
  end

  // target quadrature position and shortest way to it
  assign q_tgt  = sample_r[ANGLE_W-1 -: Q_BITS];
  assign q_diff = q_tgt - q_cur_r;

  // start-up timer
  assign timer_done = (state_r == ST_POWER_ON) ?
                      (timer_r == TIMER_W'(POWER_ON_CYCLES - 1)) :
                      (timer_r == TIMER_W'(DELAY_CYCLES - 1));

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      timer_r <= '0;
    end else if (state_r != state_nxt) begin
      timer_r <= '0;
    end else if (!timer_done) begin
      timer_r <= timer_r + TIMER_W'(1);
    end
  end

  // slew limiting
  assign slew_on    = (quadrature_slew_interval_in != SLEW_OFF);
  assign slew_ready = (slew_cnt_r == SLEW_OFF);
  assign step_now   = slew_on && slew_ready && (q_diff != QUAD_ZERO);

  // reloads on each step, so edges sit at least one interval apart
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      slew_cnt_r <= SLEW_OFF;
    end else if (step_now && (state_r == ST_CATCH_UP || state_r == ST_TRACK)) begin
      slew_cnt_r <= quadrature_slew_interval_in - SLEW_W'(1);
    end else if (!slew_ready) begin
      slew_cnt_r <= slew_cnt_r - SLEW_W'(1);
    end
  end

  // start-up sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWER_ON: begin
        if (timer_done) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        // the delay also waits for a first angle to aim at
        if (timer_done && seen_sample_r) begin
          state_nxt = slew_on ? ST_CATCH_UP : ST_TRACK;
        end
      end
      ST_CATCH_UP: begin
        if (q_diff == QUAD_ZERO) begin
          state_nxt = ST_TRACK;
        end
      end
      ST_TRACK: begin
        state_nxt = ST_TRACK;
      end
      default: begin
        state_nxt = ST_POWER_ON;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r <= ST_POWER_ON;
    end else begin
      state_r <= state_nxt;
    end
  end

  // quadrature position update
  always_comb begin
    q_nxt = q_cur_r;
    case (state_r)
      ST_POWER_ON: begin
        q_nxt = QUAD_ZERO;
      end
      ST_DELAY: begin
        q_nxt = QUAD_ZERO;
        if (timer_done && seen_sample_r && !slew_on) begin
          q_nxt = q_tgt;
        end
      end
      ST_CATCH_UP,
      ST_TRACK: begin
        if (!slew_on) begin
          q_nxt = q_tgt;
        end else if (step_now) begin
          // msb clear means the target is less than half a turn ahead
          if (!q_diff[Q_BITS-1]) begin
            q_nxt = q_cur_r + Q_BITS'(1);
          end else begin
            q_nxt = q_cur_r - Q_BITS'(1);
          end
        end
      end
      default: begin
        q_nxt = QUAD_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      q_cur_r <= QUAD_ZERO;
    end else begin
      q_cur_r <= q_nxt;
    end
  end

  assign in_power_on = (state_nxt == ST_POWER_ON);

  // A and B: state 0..3 maps to 00, 01, 11, 10
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      quad_a_out <= 1'b0;
      quad_b_out <= 1'b0;
    end else if (in_power_on) begin
      quad_a_out <= 1'b0;
      quad_b_out <= 1'b0;
    end else begin
      quad_a_out <= q_nxt[1];
      quad_b_out <= q_nxt[1] ^ q_nxt[0];
    end
  end

  // index high for 1 to 4 quadrature states from absolute zero
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      index_out <= 1'b0;
    end else if (in_power_on) begin
      index_out <= 1'b0;
    end else begin
      index_out <= (q_nxt <= Q_BITS'(index_width_sel_in));
    end
  end

  // commutation: electrical angle is mechanical angle times pole pairs
  assign pole_pairs  = POLE_CNT_W'(pole_pair_sel_in) + POLE_CNT_W'(1);
  assign elec_full   = (ANGLE_W+POLE_CNT_W)'(sample_r) * (ANGLE_W+POLE_CNT_W)'(pole_pairs);
  assign elec_angle  = elec_full[ANGLE_W-1:0];
  assign sector_full = (ANGLE_W+SECTOR_W)'(elec_angle) * (ANGLE_W+SECTOR_W)'(SECTORS);
  assign sector      = sector_full[ANGLE_W+SECTOR_W-1 -: SECTOR_W];

  // phase p is high for three sectors starting at sector 2p
  genvar p;
  generate
    for (p = 0; p < PHASE_CNT; p++) begin : g_phase
      logic [SECTOR_W-1:0] rel;
      always_comb begin
        if (sector >= SECTOR_W'(PHASE_STEP * p)) begin
          rel = sector - SECTOR_W'(PHASE_STEP * p);
        end else begin
          rel = sector + SECTOR_W'(SECTORS - PHASE_STEP * p);
        end
        phase_nxt[p] = (rel < SECTOR_W'(SECTOR_HI));
      end
    end
  endgenerate

  // held low until a first angle is known
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      phase_r <= '0;
    end else if (seen_sample_r) begin
      phase_r <= phase_nxt;
    end
  end

  assign phase_u_out = phase_r[0];
  assign phase_v_out = phase_r[1];
  assign phase_w_out = phase_r[2];

  // status and readback
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      filtered_angle_readback_out <= '0;
      rotation_head_flag_out      <= 1'b0;
      startup_done_out            <= 1'b0;
    end else begin
      filtered_angle_readback_out <= hif.filt_angle[ANGLE_W-1 -: READBACK_W];
      rotation_head_flag_out      <= hif.head_dec;
      startup_done_out            <= (state_nxt == ST_TRACK);
    end
  end

endmodule

`default_nettype wire

// ==== dv/enc_out_checker.sv ====
/*
  Checker bound to the encoder output top; sees only its ports.
  Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module enc_out_checker
  import enc_out_pkg::*;
(
  input wire logic                 clock_in,
  input wire logic                 reset_in,
  input wire logic [ANGLE_W-1:0]   angle_in,
  input wire logic                 angle_valid_in,
  input wire logic [IDX_SEL_W-1:0] index_width_sel_in,
  input wire logic [SLEW_W-1:0]    quadrature_slew_interval_in,
  input wire logic                 hysteresis_route_enable_in,
  input wire logic                 quad_a_out,
  input wire logic                 quad_b_out,
  input wire logic                 index_out,
  input wire logic                 phase_u_out,
  input wire logic                 phase_v_out,
  input wire logic                 phase_w_out,
  input wire logic                 rotation_head_flag_out,
  input wire logic                 startup_done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [1:0]  out_k;
  logic [1:0]  ang_k;
  logic [1:0]  ab_prev_r;
  logic [16:0] gap_r;
  logic        ab_chg;
  assign out_k = {quad_a_out, quad_a_out ^ quad_b_out};
  assign ang_k = angle_in[3:2];
  assign ab_chg = {quad_a_out, quad_b_out} != ab_prev_r;
  // gap saturates so long idle spells never wrap into a false short gap
  always_ff @(posedge clock_in) begin
    ab_prev_r <= {quad_a_out, quad_b_out};
    if (reset_in || ab_chg) gap_r <= 17'h00001;
    else if (gap_r != 17'h1ffff) gap_r <= gap_r + 17'h00001;
  end
  a_gray_step: assert property (
    quadrature_slew_interval_in != 16'h0000 |-> !(ab_chg && ab_prev_r[1] != quad_a_out
      && ab_prev_r[0] != quad_b_out)) else $error("quadrature lines moved together");
  a_slew_spacing: assert property (
    ab_chg && quadrature_slew_interval_in != 16'h0000
      |-> gap_r >= {1'b0, quadrature_slew_interval_in}) else $error("slew step too soon");
  a_index_width: assert property (
    startup_done_out && index_out && $stable(index_width_sel_in)
      |-> out_k <= index_width_sel_in) else $error("index outside selected width");
  a_power_on_quiet: assert property (
    $fell(reset_in) |-> (!quad_a_out && !quad_b_out && !index_out) [*3])
    else $error("outputs active in power-on interval");
  // a catch-up step into the index span moves A/B too, so only a still A/B counts
  a_delay_zero_state: assert property (
    $rose(index_out) && $stable({quad_a_out, quad_b_out}) && !startup_done_out
      |-> !quad_a_out && !quad_b_out)
    else $error("delay phase not at zero state");
  a_head_after_reset: assert property (
    $fell(reset_in) |-> !rotation_head_flag_out [*2]) else $error("head not increasing");
  a_track_direct: assert property (
    startup_done_out && angle_valid_in && !hysteresis_route_enable_in
      && quadrature_slew_interval_in == 16'h0000 |-> ##2 out_k == $past(ang_k, 2))
    else $error("quadrature state not following sample");
  a_phase_valid: assert property (
    phase_u_out || phase_v_out || phase_w_out |=> (phase_u_out || phase_v_out
      || phase_w_out) && !(phase_u_out && phase_v_out && phase_w_out))
    else $error("illegal commutation pattern");
endmodule
bind encoder_commutation_output enc_out_checker u_chk (
  .clock_in(clock_in), .reset_in(reset_in), .angle_in(angle_in),
  .angle_valid_in(angle_valid_in), .index_width_sel_in(index_width_sel_in),
  .quadrature_slew_interval_in(quadrature_slew_interval_in),
  .hysteresis_route_enable_in(hysteresis_route_enable_in),
  .quad_a_out(quad_a_out), .quad_b_out(quad_b_out), .index_out(index_out),
  .phase_u_out(phase_u_out), .phase_v_out(phase_v_out), .phase_w_out(phase_w_out),
  .rotation_head_flag_out(rotation_head_flag_out), .startup_done_out(startup_done_out)
);
`default_nettype wire

// ==== dv/enc_rx_model.sv ====
/*
  Quadrature receiver model: counts up, down and skipped A/B steps.
  Assumes the block's clock; arm_in rises once outputs are meaningful.
*/
`default_nettype none
module enc_rx_model (
  input  wire logic   clock_in,
  input  wire logic   arm_in,
  input  wire logic   quad_a_in,
  input  wire logic   quad_b_in,
  output logic [15:0] ups_out,
  output logic [15:0] downs_out,
  output logic [15:0] skips_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] state_k;
  logic [1:0] prev_r;
  assign state_k = {quad_a_in, quad_a_in ^ quad_b_in};
  always_ff @(posedge clock_in) begin
    prev_r <= state_k;
    if (!arm_in) begin // lines ignored until power-on is over
      ups_out <= '0;
      downs_out <= '0;
      skips_out <= '0;
    end else if (state_k - prev_r == 2'd1) ups_out <= ups_out + 16'h0001;
    else if (state_k - prev_r == 2'd3) downs_out <= downs_out + 16'h0001;
    else if (state_k - prev_r == 2'd2) skips_out <= skips_out + 16'h0001;
  end
endmodule
`default_nettype wire

// ==== dv/tb_encoder_commutation_output.sv ====
/*
  Self-checking bench for the encoder and commutation output block.
  Assumes short power-on and delay counts and a quadrature receiver model.
*/
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_encoder_commutation_output
  import enc_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ANGLE_W-1:0] ang = '0;
  logic vld = 1'b0;
  logic [3:0] psel = '0;
  logic [1:0] isel = '0;
  logic [SLEW_W-1:0] slew = '0;
  logic route = 1'b0;
  logic [WINDOW_W-1:0] win = '0;
  logic arm = 1'b0;
  logic qa, qb, idx, pu, pv, pw, flag, done;
  logic [11:0] rb;
  logic [15:0] rx_up, rx_dn, rx_sk;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  encoder_commutation_output #(.POWER_ON_CYCLES(4), .DELAY_CYCLES(4)) dut (
    .clock_in(clk), .reset_in(rst), .angle_in(ang), .angle_valid_in(vld),
    .pole_pair_sel_in(psel), .index_width_sel_in(isel),
    .quadrature_slew_interval_in(slew), .angle_window_width_in(win),
    .hysteresis_route_enable_in(route), .quad_a_out(qa), .quad_b_out(qb),
    .index_out(idx), .phase_u_out(pu), .phase_v_out(pv), .phase_w_out(pw),
    .filtered_angle_readback_out(rb), .rotation_head_flag_out(flag),
    .startup_done_out(done));
  enc_rx_model rx (.clock_in(clk), .arm_in(arm), .quad_a_in(qa), .quad_b_in(qb),
    .ups_out(rx_up), .downs_out(rx_dn), .skips_out(rx_sk));
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      fails++;
      results();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(int a);
    ang = a[ANGLE_W-1:0];
    vld = 1'b1;
    step(1);
    vld = 1'b0;
  endtask
  task automatic do_reset(logic [SLEW_W-1:0] s, logic r, logic [WINDOW_W-1:0] w);
    arm = 1'b0;
    slew = s;
    route = r;
    win = w;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(10);
    `CHK({qa, qb, idx, flag}, 4'b0010)
    arm = 1'b1;
  endtask
  task automatic wait_done(int lim);
    int n = 0;
    while (done !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    `CHK(n < lim, 1'b1)
    step(2);
  endtask
  function automatic logic [2:0] uvw_of(int s);
    case (s)
      0: return 3'b101;
      1: return 3'b100;
      2: return 3'b110;
      3: return 3'b010;
      4: return 3'b011;
      default: return 3'b001;
    endcase
  endfunction
  task automatic t_catchup();
    do_reset(16'h0002, 1'b0, 6'h00);
    send(12000);
    wait_done(2 * 2048 + 8);
    `CHK(rx_up, 16'h0000)
    `CHK(rx_dn, 16'h0448)
    `CHK(rx_sk, 16'h0000)
  endtask
  task automatic t_jump();
    do_reset(16'h0000, 1'b0, 6'h00);
    send(12);
    wait_done(10);
    `CHK({qa, qb}, 2'b10)
  endtask
  task automatic t_track();
    for (int s = 0; s < 4; s++) begin
      isel = s[1:0];
      for (int q = 0; q < 6; q++) begin
        send(q * 4);
        step(3);
        `CHK({qa, qb}, {q[1], q[1] ^ q[0]})
        `CHK(idx, 1'(q <= s))
      end
    end
  endtask
  task automatic t_commute();
    for (int n = 0; n < 16; n++) begin
      psel = n[3:0];
      send(5000);
      step(4);
      `CHK({pu, pv, pw}, uvw_of((5000 * (n + 1)) % 16384 * 6 / 16384))
    end
    psel = 4'h2;
    for (int i = 0; i < 18; i++) begin
      send(i * 910 + 455);
      step(4);
      `CHK({pu, pv, pw}, uvw_of(i % 6))
    end
  endtask
  task automatic t_hyst();
    int a[7] = '{992, 991, 999, 980, 988, 989, 1100};
    int g[7] = '{1000, 991, 991, 980, 980, 989, 1100};
    logic f[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    psel = 4'ha; // eleven pairs put a sector edge between 992 and 993
    do_reset(16'h0003, 1'b1, 6'h08); // slew on since window is wide
    send(1000);
    wait_done(800);
    step(20);
    `CHK(rb, 12'h0fa)
    for (int i = 0; i < 7; i++) begin
      send(a[i]);
      step(100);
      `CHK(rb, 12'(g[i] >> 2))
      `CHK(flag, f[i])
      `CHK(rx_up - rx_dn, 16'(g[i] >> 2))
      `CHK({pu, pv, pw}, uvw_of((g[i] * 11) % 16384 * 6 / 16384))
    end
    `CHK(rx_sk, 16'h0000)
  endtask
  initial begin
    t_catchup();
    t_jump();
    t_track();
    t_commute();
    t_hyst();
    results();
  end
endmodule
`default_nettype wire
